// >>> design/sbe_status_core.sv
// Standard event latch, status byte and service request logic.
`timescale 1ns/1ns
`default_nettype none
module sbe_status_core
  import sbe_pkg::*;
#(
  parameter int unsigned ERR_W = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // Power-on and its clear option
  input  wire logic             power_on_i,
  input  wire logic             power_on_clear_i,
  // Events from the command engine
  input  wire sbe_events_t      events_i,
  input  wire logic [ERR_W-1:0] err_code_i,
  input  wire logic             err_pop_i,
  // Commands, executed in command order
  input  wire sbe_cmd_t         cmd_i,
  input  wire logic             byte_query_i,
  // Summary sources
  input  wire logic             questionable_summary_bit_summary_i,
  input  wire logic             out_data_waiting_i,
  // Bus interface serial poll
  input  wire logic             serial_poll_i,
  // Read results
  output logic      [7:0]       event_data_o,
  output logic      [7:0]       event_mask_o,
  output logic      [7:0]       service_mask_o,
  output logic      [7:0]       status_byte_o,
  output logic      [7:0]       poll_byte_o,
  output logic                  poll_valid_o,
  output logic      [7:0]       query_byte_o,
  output logic                  query_valid_o,
  output logic      [ERR_W-1:0] err_code_o,
  output logic                  err_pending_o,
  output logic                  service_req_o
);

  typedef struct packed {
    sbe_state_t state;
    logic [7:0] standard_event_latch;
    logic [7:0] event_mask;
    logic [7:0] service_mask;
    logic [7:0] summary_status_byte;
    logic       rqs_armed;
    logic       srq_prev;
    logic [7:0] event_data;
    logic [7:0] poll_byte;
    logic       poll_valid;
    logic [7:0] query_byte;
    logic       query_valid;
    logic       service_req;
  } sbe_core_state_t;

  sbe_core_state_t st_reg;
  sbe_core_state_t st_next;
  logic            err_push;
  logic            err_flush;

  // Builds the status byte from live sources; used for both live and read-out values.
  function automatic logic [7:0] build_byte(input logic [7:0] ev, input logic [7:0] ev_mask,
                                            input logic questionable_summary_bit, input logic message_waiting_bit,
                                            input logic service_request_bit);
    logic [7:0] b;
    b = 8'h00;
    b[SB_QUESTIONABLE_SUMMARY_BIT_POS] = questionable_summary_bit;
    b[SB_MAV_POS]  = message_waiting_bit;
    b[SB_ESB_POS]  = |(ev & ev_mask & EV_USED_MASK);
    b[SB_RQS_POS]  = service_request_bit;
    return b;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] set_bits;
    logic [7:0] ev;
    logic [7:0] sb;
    logic       srq_cond;
    logic       service_request_bit;
    logic       rise;
    st_next  = st_reg;
    set_bits = 8'h00;
    ev       = 8'h00;
    sb       = 8'h00;
    srq_cond = 1'b0;
    service_request_bit      = 1'b0;
    rise     = 1'b0;
    err_push = 1'b0;
    err_flush = 1'b0;
    set_bits[EV_OPC_POS] = events_i.op_done;
    set_bits[EV_QRY_POS] = events_i.query_fault;
    set_bits[EV_DEV_POS] = events_i.device_fault;
    set_bits[EV_EXE_POS] = events_i.execution_fault;
    set_bits[EV_SYN_POS] = events_i.syntax_fault;
    err_push = events_i.query_fault | events_i.device_fault
             | events_i.execution_fault | events_i.syntax_fault;
    ev = st_reg.standard_event_latch;
    st_next.poll_valid  = 1'b0;
    st_next.query_valid = 1'b0;
    case (st_reg.state)
      SBE_ST_BOOT: begin
        st_next.state = SBE_ST_RUN;
      end
      SBE_ST_HOLD: begin
        st_next.state = SBE_ST_RUN;
      end
      default: begin
        st_next.state = SBE_ST_RUN;
      end
    endcase
    if (power_on_i) begin
      ev[EV_PWR_POS] = 1'b1;
      if (power_on_clear_i) begin
        st_next.event_mask   = MASK_RESET_VAL;
        st_next.service_mask = MASK_RESET_VAL;
      end
    end
    if (cmd_i.event_read) begin
      st_next.event_data = ev & EV_USED_MASK;
    end
    if (cmd_i.clear_status || cmd_i.event_read) begin
      ev = 8'h00;
    end
    if (cmd_i.clear_status) begin
      err_flush = 1'b1;
    end
    // New events win over a clear in the same cycle.
    ev = (ev | set_bits) & EV_USED_MASK;
    st_next.standard_event_latch = ev;
    // Writes load the masks with the written value, with the bits outside EV_USED_MASK or SB_SUM_MASK forced to zero.
    if (cmd_i.event_mask_wr) begin
      st_next.event_mask = cmd_i.wdata & EV_USED_MASK;
    end
    if (cmd_i.service_mask_wr) begin
      st_next.service_mask = cmd_i.wdata & SB_SUM_MASK;
    end
    // Masks written in this cycle already count, so a mask write shows in the
    // byte after one cycle like any other source does.
    sb = build_byte(ev, st_next.event_mask, questionable_summary_bit_summary_i, out_data_waiting_i, 1'b0);
    srq_cond = |(sb & st_next.service_mask & SB_SUM_MASK);
    rise     = srq_cond && !st_reg.srq_prev;
    // A new rising of the request arms the service bit; it stays armed until a poll,
    // a clear or until its causing source goes away, which an event read achieves when the source is the event summary bit.
    service_request_bit = st_reg.rqs_armed;
    if (rise) begin
      service_request_bit = 1'b1;
    end
    if (!srq_cond) begin
      service_request_bit = 1'b0;
    end
    // A request that rises in the cycle of a poll or a clear survives it, so
    // that no request is lost.
    if (serial_poll_i) begin
      st_next.poll_byte = build_byte(ev, st_next.event_mask, questionable_summary_bit_summary_i,
                                     out_data_waiting_i, service_request_bit);
      st_next.poll_valid = 1'b1;
      if (!rise) begin
        service_request_bit = 1'b0;
      end
    end
    if (cmd_i.clear_status && !rise) begin
      service_request_bit = 1'b0;
    end
    if (byte_query_i) begin
      // Served from the command stream, so it reflects all earlier commands.
      st_next.query_byte = build_byte(ev, st_next.event_mask, questionable_summary_bit_summary_i,
                                      out_data_waiting_i, service_request_bit);
      st_next.query_valid = 1'b1;
    end
    if (cmd_i.event_read) begin
      st_next.state = SBE_ST_HOLD;
    end
    st_next.rqs_armed = service_request_bit;
    st_next.srq_prev  = srq_cond;
    st_next.summary_status_byte = build_byte(ev, st_next.event_mask, questionable_summary_bit_summary_i,
                                             out_data_waiting_i, service_request_bit);
    st_next.service_req = service_request_bit;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_reg                      <= '0;
      st_reg.state                <= SBE_ST_BOOT;
      st_reg.standard_event_latch <= EV_RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Error queue
  // ------------------------------------------------------------
  sbe_error_queue #(
    .WIDTH (ERR_W),
    .DEPTH (ERRQ_DEPTH)
  ) u_errq (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .push_i      (err_push),
    .push_code_i (err_code_i),
    .pop_i       (err_pop_i),
    .flush_i     (err_flush),
    .pop_code_o  (err_code_o),
    .not_empty_o (err_pending_o)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign event_data_o   = st_reg.event_data;
  assign event_mask_o   = st_reg.event_mask;
  assign service_mask_o = st_reg.service_mask;
  assign status_byte_o  = st_reg.summary_status_byte;
  assign poll_byte_o    = st_reg.poll_byte;
  assign poll_valid_o   = st_reg.poll_valid;
  assign query_byte_o   = st_reg.query_byte;
  assign query_valid_o  = st_reg.query_valid;
  assign service_req_o  = st_reg.service_req;

endmodule
`default_nettype wire

// >>> design/sbe_pkg.sv
// Package of constants and carrier types for the status byte and event reporting block.
package sbe_pkg;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned EV_OPC_POS  = 0;
  localparam int unsigned EV_QRY_POS  = 2;
  localparam int unsigned EV_DEV_POS  = 3;
  localparam int unsigned EV_EXE_POS  = 4;
  localparam int unsigned EV_SYN_POS  = 5;
  localparam int unsigned EV_PWR_POS  = 7;
  localparam int unsigned SB_QUESTIONABLE_SUMMARY_BIT_POS = 3;
  localparam int unsigned SB_MAV_POS  = 4;
  localparam int unsigned SB_ESB_POS  = 5;
  localparam int unsigned SB_RQS_POS  = 6;

  // ------------------------------------------------------------
  // Masks, reset values and error queue sizes
  // ------------------------------------------------------------
  localparam logic [7:0] EV_USED_MASK    = 8'hBD;
  localparam logic [7:0] SB_SUM_MASK     = 8'h38;
  localparam logic [7:0] EV_RESET_VALUE  = 8'h80;
  localparam logic [7:0] MASK_RESET_VAL  = 8'h00;
  localparam int unsigned ERRQ_DEPTH     = 20;
  localparam int unsigned ERRQ_AW        = 5;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SBE_ST_BOOT = 3'b001,
    SBE_ST_RUN  = 3'b010,
    SBE_ST_HOLD = 3'b100
  } sbe_state_t;

  typedef struct packed {
    logic op_done;
    logic query_fault;
    logic device_fault;
    logic execution_fault;
    logic syntax_fault;
  } sbe_events_t;

  typedef struct packed {
    logic       clear_status;
    logic       event_read;
    logic       event_mask_wr;
    logic       service_mask_wr;
    logic [7:0] wdata;
  } sbe_cmd_t;

endpackage

// >>> design/sbe_error_queue.sv
// Small error queue memory that keeps error codes in arrival order.
`timescale 1ns/1ns
`default_nettype none
module sbe_error_queue
  import sbe_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = ERRQ_DEPTH
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // Write side
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_code_i,
  // Read side
  input  wire logic             pop_i,
  input  wire logic             flush_i,
  output logic      [WIDTH-1:0] pop_code_o,
  output logic                  not_empty_o
);

  typedef struct packed {
    logic [ERRQ_AW-1:0] wptr;
    logic [ERRQ_AW-1:0] rptr;
    logic [ERRQ_AW:0]   count;
    logic [WIDTH-1:0]   rdata;
    logic               not_empty;
  } sbe_q_state_t;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  sbe_q_state_t     st_reg;
  sbe_q_state_t     st_next;
  logic             do_pop;
  logic             do_push;

  // ------------------------------------------------------------
  // Pointer logic
  // ------------------------------------------------------------
  // When full the newest entry is overwritten, so an overflow still leaves a trace.
  always_comb begin
    st_next = st_reg;
    do_pop  = pop_i && (st_reg.count != '0);
    do_push = push_i;
    if (flush_i) begin
      // A fault that arrives with the flush is kept, so its event bit still has an entry.
      st_next.wptr  = do_push ? ERRQ_AW'(1) : '0;
      st_next.rptr  = '0;
      st_next.count = do_push ? (ERRQ_AW + 1)'(1) : '0;
      do_pop        = 1'b0;
    end else begin
      if (do_pop) begin
        st_next.rdata = mem_reg[st_reg.rptr];
        st_next.rptr  = (st_reg.rptr == ERRQ_AW'(DEPTH - 1)) ? '0 : st_reg.rptr + 1'b1;
      end
      if (do_push && (st_reg.count != (ERRQ_AW + 1)'(DEPTH) || do_pop)) begin
        st_next.wptr = (st_reg.wptr == ERRQ_AW'(DEPTH - 1)) ? '0 : st_reg.wptr + 1'b1;
      end
      if (do_push && !do_pop && st_reg.count != (ERRQ_AW + 1)'(DEPTH)) begin
        st_next.count = st_reg.count + 1'b1;
      end else if (do_pop && !do_push) begin
        st_next.count = st_reg.count - 1'b1;
      end
    end
    st_next.not_empty = (st_next.count != '0);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      if (flush_i) begin
        mem_reg[0] <= push_code_i;
      end else if (st_reg.count == (ERRQ_AW + 1)'(DEPTH) && !do_pop) begin
        mem_reg[(st_reg.wptr == '0) ? ERRQ_AW'(DEPTH - 1) : st_reg.wptr - 1'b1] <= push_code_i;
      end else begin
        mem_reg[st_reg.wptr] <= push_code_i;
      end
    end
  end

  assign pop_code_o  = st_reg.rdata;
  assign not_empty_o = st_reg.not_empty;

endmodule
`default_nettype wire

// >>> tb/sbe_status_asserts.sv
// Port checker for the status core, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module sbe_status_asserts
  import sbe_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        power_on_i,
  input wire logic        power_on_clear_i,
  input wire sbe_events_t events_i,
  input wire sbe_cmd_t    cmd_i,
  input wire logic        byte_query_i,
  input wire logic        questionable_summary_bit_summary_i,
  input wire logic        out_data_waiting_i,
  input wire logic        serial_poll_i,
  // Outputs
  input wire logic [7:0]  event_data_o,
  input wire logic [7:0]  event_mask_o,
  input wire logic [7:0]  service_mask_o,
  input wire logic [7:0]  status_byte_o,
  input wire logic [7:0]  poll_byte_o,
  input wire logic        poll_valid_o,
  input wire logic [7:0]  query_byte_o,
  input wire logic        query_valid_o,
  input wire logic        err_pending_o,
  input wire logic        service_req_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // No event, command or power pulse in the cycle, so the event latch and the masks cannot move.
  wire logic quiet = !(|events_i) && cmd_i == '0 && !power_on_i;
  wire logic no_wr = !cmd_i.event_mask_wr && !cmd_i.service_mask_wr;

  chk_unused_zero: assert property (status_byte_o[2:0] == 3'h0 && !status_byte_o[7]
    && !event_data_o[1] && !event_data_o[6]) else $error("unused bit set");
  chk_rqs_line: assert property (service_req_o == status_byte_o[6])
    else $error("request line differs from bit 6");
  chk_questionable_summary_bit_follow: assert property (!$past(srst_i) && !$past(cmd_i.clear_status)
    |-> status_byte_o[3] == $past(questionable_summary_bit_summary_i)) else $error("bit 3 lags source");
  chk_mav_follow: assert property (!$past(srst_i) && !$past(cmd_i.clear_status)
    |-> status_byte_o[4] == $past(out_data_waiting_i)) else $error("bit 4 lags source");
  chk_poll_result: assert property (serial_poll_i && quiet && $stable(questionable_summary_bit_summary_i)
    && $stable(out_data_waiting_i) |=> poll_valid_o && poll_byte_o == $past(status_byte_o)
    && !status_byte_o[6] && status_byte_o[5] == $past(status_byte_o[5]))
    else $error("poll result wrong");
  chk_query_clean: assert property (byte_query_i && quiet && !serial_poll_i
    && $stable(questionable_summary_bit_summary_i) && $stable(out_data_waiting_i) |=> query_valid_o
    && query_byte_o == $past(status_byte_o) && $stable(status_byte_o[6]))
    else $error("query result wrong");
  chk_mask_load: assert property (cmd_i.event_mask_wr && !power_on_i
    |=> event_mask_o == ($past(cmd_i.wdata) & EV_USED_MASK))
    else $error("event mask not loaded");
  chk_srv_load: assert property (cmd_i.service_mask_wr && !power_on_i
    |=> service_mask_o == ($past(cmd_i.wdata) & SB_SUM_MASK)) else $error("service mask");
  chk_read_esb: assert property (cmd_i.event_read && !(|events_i) && !power_on_i
    |=> !status_byte_o[5]) else $error("bit 5 kept after read");
  chk_psc_zero: assert property (power_on_i && power_on_clear_i && no_wr
    |=> event_mask_o == 8'h00 && service_mask_o == 8'h00) else $error("masks kept");
  chk_psc_keep: assert property (power_on_i && !power_on_clear_i && no_wr
    |=> $stable(event_mask_o) && $stable(service_mask_o)) else $error("masks lost");
  chk_err_push: assert property ((|events_i[3:0])
    |=> err_pending_o) else $error("fault not queued");
  chk_clear_all: assert property (cmd_i.clear_status && !(|events_i) && !power_on_i
    && no_wr && $stable(questionable_summary_bit_summary_i) && $stable(out_data_waiting_i) |=>
    status_byte_o[6:5] == 2'b00 && !err_pending_o && $stable(event_mask_o))
    else $error("clear status wrong");

  cover property (serial_poll_i && status_byte_o[6]);
  cover property (byte_query_i && status_byte_o[6]);
  cover property (power_on_i && power_on_clear_i);
endmodule
bind sbe_status_core sbe_status_asserts i_chk (.clock_i, .srst_i, .power_on_i,
  .power_on_clear_i, .events_i, .cmd_i, .byte_query_i, .questionable_summary_bit_summary_i,
  .out_data_waiting_i, .serial_poll_i, .event_data_o, .event_mask_o, .service_mask_o,
  .status_byte_o, .poll_byte_o, .poll_valid_o, .query_byte_o, .query_valid_o,
  .err_pending_o, .service_req_o);
`default_nettype wire

// >>> tb/sbe_bus_ctrl.sv
// Bus controller model that issues serial polls.
`timescale 1ns/1ns
`default_nettype none
module sbe_bus_ctrl
  import sbe_pkg::*;
(
  // Clock and poll answer
  input  wire logic       clock_i,
  input  wire logic [7:0] poll_byte_i,
  input  wire logic       poll_valid_i,
  // Poll request
  output logic            serial_poll_o
);
  initial serial_poll_o = 1'b0;
  // Idle cycles first, so earlier commands finish before the poll is trusted.
  task automatic poll(input int gap, output logic [7:0] b, output logic ok);
    repeat (gap) @(negedge clock_i);
    serial_poll_o = 1'b1;
    @(negedge clock_i);
    serial_poll_o = 1'b0;
    ok = (poll_valid_i === 1'b1);
    b = poll_byte_i;
  endtask
endmodule
`default_nettype wire

// >>> tb/status_byte_event_reporting_bench.sv
// Self-checking bench for the status core.
`timescale 1ns/1ns
`default_nettype none
module status_byte_event_reporting_bench;
  import sbe_pkg::*;
  logic        clock_i = 0, srst_i = 1, power_on_i = 0, power_on_clear_i = 0;
  logic        byte_query_i = 0, questionable_summary_bit_summary_i = 0, out_data_waiting_i = 0, err_pop_i = 0;
  sbe_events_t events_i = '0;
  sbe_cmd_t    cmd_i = '0;
  logic [7:0]  err_code_i = 8'h5A, b;
  wire logic   serial_poll_i;
  logic [7:0]  event_data_o, event_mask_o, service_mask_o, status_byte_o;
  logic [7:0]  poll_byte_o, query_byte_o, err_code_o;
  logic        poll_valid_o, query_valid_o, err_pending_o, service_req_o, ok;
  int          n_errors = 0, checks = 0;
  logic [7:0]  evx [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};

  sbe_status_core i_dut (.clock_i, .srst_i, .power_on_i, .power_on_clear_i, .events_i,
    .err_code_i, .err_pop_i, .cmd_i, .byte_query_i, .questionable_summary_bit_summary_i, .out_data_waiting_i,
    .serial_poll_i, .event_data_o, .event_mask_o, .service_mask_o, .status_byte_o,
    .poll_byte_o, .poll_valid_o, .query_byte_o, .query_valid_o, .err_code_o,
    .err_pending_o, .service_req_o);
  sbe_bus_ctrl i_ctrl (.clock_i, .poll_byte_i(poll_byte_o), .poll_valid_i(poll_valid_o),
    .serial_poll_o(serial_poll_i));

  always #20 clock_i = ~clock_i;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One pulse taken at a rising edge; results are settled when this returns.
  task automatic drive(input sbe_events_t e, input sbe_cmd_t c, input logic q);
    @(negedge clock_i);
    events_i = e;
    cmd_i = c;
    byte_query_i = q;
    @(negedge clock_i);
    events_i = '0;
    cmd_i = '0;
    byte_query_i = 1'b0;
  endtask
  task automatic cmd(input logic [3:0] k, input logic [7:0] d);
    drive('0, sbe_cmd_t'({k, d}), 1'b0);
  endtask
  task automatic rd(input logic [7:0] exp);
    cmd(4'h4, 8'h00);
    check("event", event_data_o, exp);
  endtask
  task automatic pw(input logic clr);
    power_on_clear_i = clr;
    @(negedge clock_i);
    power_on_i = 1'b1;
    @(negedge clock_i);
    power_on_i = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock_i);
    n_errors++;
    $display("[FAIL] run expected end seen hang");
    print_verdict();
  end

  initial begin
    repeat (20) @(negedge clock_i);
    srst_i = 1'b0;
    check("status", status_byte_o, 8'h00);
    rd(8'h80);
    rd(8'h00);
    for (int i = 0; i < 5; i++) begin
      drive(sbe_events_t'(5'h10 >> i), '0, 1'b0);
      repeat (3) @(negedge clock_i);
      rd(evx[i]);
      check("pending", {7'h00, err_pending_o}, {7'h00, i != 0});
      if (i != 0) begin
        err_pop_i = 1'b1;
        @(negedge clock_i);
        err_pop_i = 1'b0;
        check("code", err_code_o, 8'h5A);
      end
    end
    questionable_summary_bit_summary_i = 1'b1;
    out_data_waiting_i = 1'b1;
    cmd(4'h2, 8'h20);
    cmd(4'h1, 8'h20);
    check("status", status_byte_o, 8'h18);
    drive(5'h01, '0, 1'b0);
    check("status", status_byte_o, 8'h78);
    drive('0, '0, 1'b1);
    check("query", query_byte_o, 8'h78);
    check("query ok", {7'h00, query_valid_o}, 8'h01);
    check("status", status_byte_o, 8'h78);
    i_ctrl.poll(2, b, ok);
    check("poll", b, 8'h78);
    check("poll ok", {7'h00, ok}, 8'h01);
    check("status", status_byte_o, 8'h38);
    rd(8'h20);
    check("status", status_byte_o, 8'h18);
    drive(5'h01, '0, 1'b0);
    rd(8'h20);
    check("rqs", {7'h00, service_req_o}, 8'h00);
    out_data_waiting_i = 1'b0;
    questionable_summary_bit_summary_i = 1'b0;
    @(negedge clock_i);
    check("status", status_byte_o, 8'h00);
    cmd(4'h1, 8'h00);
    check("smask", service_mask_o, 8'h00);
    drive(5'h02, '0, 1'b0);
    cmd(4'h2, 8'h10);
    check("status", status_byte_o, 8'h20);
    cmd(4'h2, 8'h00);
    check("status", status_byte_o, 8'h00);
    cmd(4'h2, 8'h10);
    cmd(4'h1, 8'h20);
    check("status", status_byte_o, 8'h60);
    cmd(4'h8, 8'h00);
    check("status", status_byte_o, 8'h00);
    check("emask", event_mask_o, 8'h10);
    pw(1'b0);
    check("smask", service_mask_o, 8'h20);
    rd(8'h80);
    pw(1'b1);
    check("emask", event_mask_o, 8'h00);
    check("smask", service_mask_o, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
